// [src/ctc_common_timer_ctrl.sv]
// common control bank for three pwm timer channels: launch, halt, break select,
// buffer-transfer pause and the adc-trigger threshold staging copies
// assumes a register master on ref_clk with one-cycle strobes, channel mode
// enables and transfer points from logic on ref_clk, and a debug break level
// that may come from another domain
`include "ctc_params.svh"
`default_nettype none

module ctc_common_timer_ctrl (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [`CTC_ADDR_W-1:0] reg_addr,
    input wire logic [`CTC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`CTC_DATA_W-1:0] reg_rdata,
    input wire logic dbg_break,
    input wire logic [`CTC_PAUSE_W-1:0] buf_en,
    input wire logic [`CTC_NUM_CH-1:0] xfer_point,
    output logic [`CTC_NUM_CH-1:0] chan_running,
    output logic [`CTC_NUM_CH-1:0] cnt_enable,
    output logic [`CTC_NUM_CH-1:0] cnt_init,
    output logic [`CTC_PAUSE_W-1:0] xfer_ok,
    output logic read_delay_mask,
    output logic [2*`CTC_NUM_CH*`CTC_THR_W-1:0] adc_thr_active
);

    ctc_pkg::ctc_top_st_t st_r;
    ctc_pkg::ctc_top_st_t st_nxt;

    logic brk_sync;
    logic [2*`CTC_NUM_CH*`CTC_THR_W-1:0] stage_q;
    logic [`CTC_NUM_CH-1:0] pause_adc;
    logic [`CTC_NUM_CH-1:0] buf_en_adc;
    logic [`CTC_ADDR_W-1:0] adc_off;
    logic adc_hit;
    logic [2:0] adc_idx;
    logic [6:0] adc_lsb;
    logic stage_wr;
    ctc_pkg::ctc_reg_sel_t sel;

    ////////////////////////////////////////////////////////////////////////////
    // debug break may arrive from the cpu core's own timing
    ctc_sync u_brk_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .level_in(dbg_break),
        .level_out(brk_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // address decode; staging copies sit at base + 16*channel, b at +8
    always_comb begin
        adc_off = reg_addr - `CTC_OFS_ADC_BASE;
        adc_hit = (reg_addr >= `CTC_OFS_ADC_BASE) && (reg_addr <= `CTC_OFS_ADC_LAST) &&
                  (adc_off[2:0] == 3'h0);
        adc_idx = {adc_off[5:4], adc_off[3]};
        adc_lsb = {adc_idx, 4'h0};
        unique case (reg_addr)
            `CTC_OFS_LAUNCH: sel = ctc_pkg::CTC_SEL_LAUNCH;
            `CTC_OFS_HALT: sel = ctc_pkg::CTC_SEL_HALT;
            `CTC_OFS_PAUSE: sel = ctc_pkg::CTC_SEL_PAUSE;
            `CTC_OFS_BRKSEL: sel = ctc_pkg::CTC_SEL_BRK;
            default: sel = adc_hit ? ctc_pkg::CTC_SEL_ADC : ctc_pkg::CTC_SEL_NONE;
        endcase
    end

    assign stage_wr = reg_wr && (sel == ctc_pkg::CTC_SEL_ADC);

    ////////////////////////////////////////////////////////////////////////////
    // per-channel gathering of the adc-trigger pause bits and enables
    genvar g;
    generate
        for (g = 0; g < `CTC_NUM_CH; g++) begin : g_adc_bits
            assign pause_adc[g] = st_r.pause[g*`CTC_KINDS + `CTC_PAUSE_ADC];
            assign buf_en_adc[g] = buf_en[g*`CTC_KINDS + `CTC_PAUSE_ADC];
        end
    endgenerate

    ctc_adc_stage u_adc_stage (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .wr_en(stage_wr),
        .wr_idx(adc_idx),
        .wr_data(reg_wdata[`CTC_THR_W-1:0]),
        .pause_adc(pause_adc),
        .buf_en_adc(buf_en_adc),
        .xfer_point(xfer_point),
        .stage_q(stage_q),
        .act_q(adc_thr_active)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        st_nxt.init = '0;
        st_nxt.rdata = '0;

        if (reg_wr) begin
            unique case (sel)
                ctc_pkg::CTC_SEL_LAUNCH: begin
                    for (int c = 0; c < `CTC_NUM_CH; c++) begin
                        // a start always begins from a fresh count
                        if (reg_wdata[`CTC_CH_LSB + c]) begin
                            st_nxt.run[c] = 1'b1;
                            st_nxt.init[c] = 1'b1;
                        end
                    end
                end
                ctc_pkg::CTC_SEL_HALT: begin
                    for (int c = 0; c < `CTC_NUM_CH; c++) begin
                        if (reg_wdata[`CTC_CH_LSB + c]) begin
                            st_nxt.run[c] = 1'b0;
                        end
                    end
                end
                ctc_pkg::CTC_SEL_PAUSE: begin
                    st_nxt.pause = reg_wdata[`CTC_PAUSE_W-1:0];
                end
                ctc_pkg::CTC_SEL_BRK: begin
                    st_nxt.brk_run = reg_wdata[`CTC_CH_LSB +: `CTC_NUM_CH];
                    st_nxt.rd_mask = reg_wdata[`CTC_RDMASK_BIT];
                end
                default: begin
                end
            endcase
        end

        if (reg_rd) begin
            unique case (sel)
                ctc_pkg::CTC_SEL_LAUNCH: begin
                    st_nxt.rdata[`CTC_CH_LSB +: `CTC_NUM_CH] = st_r.run;
                end
                ctc_pkg::CTC_SEL_PAUSE: begin
                    st_nxt.rdata[`CTC_PAUSE_W-1:0] = st_r.pause;
                end
                ctc_pkg::CTC_SEL_BRK: begin
                    st_nxt.rdata[`CTC_CH_LSB +: `CTC_NUM_CH] = st_r.brk_run;
                    st_nxt.rdata[`CTC_RDMASK_BIT] = st_r.rd_mask;
                end
                ctc_pkg::CTC_SEL_ADC: begin
                    st_nxt.rdata[`CTC_THR_W-1:0] = stage_q[adc_lsb +: `CTC_THR_W];
                end
                // halt is write-only and unmapped reads return zero
                default: begin
                end
            endcase
        end

        // break freezes a channel unless it was told to keep counting
        st_nxt.cnt_en = st_nxt.run & ~({`CTC_NUM_CH{brk_sync}} & ~st_nxt.brk_run);

        // the channel's own mode bits are the second half of the condition
        st_nxt.xfer_ok = ~st_nxt.pause & buf_en;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r.run <= `CTC_RST_RUN;
            st_r.brk_run <= `CTC_RST_BRKSEL;
            st_r.rd_mask <= `CTC_RST_RDMASK;
            st_r.pause <= `CTC_RST_PAUSE;
            st_r.init <= '0;
            st_r.cnt_en <= '0;
            st_r.xfer_ok <= '0;
            st_r.rdata <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign reg_rdata = st_r.rdata;
    assign chan_running = st_r.run;
    assign cnt_enable = st_r.cnt_en;
    assign cnt_init = st_r.init;
    assign xfer_ok = st_r.xfer_ok;
    assign read_delay_mask = st_r.rd_mask;

endmodule : ctc_common_timer_ctrl

`default_nettype wire

// [common/ctc_params.svh]
// constants of the common timer control bank: offsets, bit positions, reset values
// assumes a byte-addressed register port with 8 address bits and 32 data bits
`ifndef CTC_PARAMS_SVH
`define CTC_PARAMS_SVH

`define CTC_NUM_CH 3
`define CTC_ADDR_W 8
`define CTC_DATA_W 32
`define CTC_THR_W 16
`define CTC_KINDS 4
`define CTC_PAUSE_W 12

// register offsets
`define CTC_OFS_LAUNCH 8'h00
`define CTC_OFS_HALT 8'h04
`define CTC_OFS_PAUSE 8'h48
`define CTC_OFS_BRKSEL 8'h4c
`define CTC_OFS_ADC_BASE 8'h80
`define CTC_OFS_ADC_LAST 8'ha8

// field positions
`define CTC_CH_LSB 16
`define CTC_RDMASK_BIT 15
`define CTC_PAUSE_PERIOD 0
`define CTC_PAUSE_THA 1
`define CTC_PAUSE_DEAD 2
`define CTC_PAUSE_ADC 3

// reset values
`define CTC_RST_RUN 3'h0
`define CTC_RST_BRKSEL 3'h0
`define CTC_RST_RDMASK 1'h0
`define CTC_RST_PAUSE 12'h000
`define CTC_RST_THR 16'h0000

`endif

// [common/ctc_pkg.sv]
// types of the common timer control bank
// assumes ctc_params.svh is on the include path
`include "ctc_params.svh"
`default_nettype none

package ctc_pkg;

    typedef enum logic [2:0] {
        CTC_SEL_NONE   = 3'b000,
        CTC_SEL_LAUNCH = 3'b001,
        CTC_SEL_HALT   = 3'b010,
        CTC_SEL_PAUSE  = 3'b011,
        CTC_SEL_BRK    = 3'b100,
        CTC_SEL_ADC    = 3'b101
    } ctc_reg_sel_t;

    typedef struct packed {
        logic [`CTC_NUM_CH-1:0] run;
        logic [`CTC_NUM_CH-1:0] brk_run;
        logic rd_mask;
        logic [`CTC_PAUSE_W-1:0] pause;
        logic [`CTC_NUM_CH-1:0] init;
        logic [`CTC_NUM_CH-1:0] cnt_en;
        logic [`CTC_PAUSE_W-1:0] xfer_ok;
        logic [`CTC_DATA_W-1:0] rdata;
    } ctc_top_st_t;

    typedef struct packed {
        logic [2*`CTC_NUM_CH-1:0][`CTC_THR_W-1:0] stage;
        logic [2*`CTC_NUM_CH-1:0][`CTC_THR_W-1:0] act;
    } ctc_stage_st_t;

    typedef struct packed {
        logic meta;
        logic sync;
    } ctc_sync_st_t;

endpackage : ctc_pkg

`default_nettype wire

// [src/ctc_sync.sv]
// two flip-flop synchroniser for one level
// assumes the input may change at any time relative to ref_clk
`include "ctc_params.svh"
`default_nettype none

module ctc_sync (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic level_in,
    output logic level_out
);

    ctc_pkg::ctc_sync_st_t st_r;
    ctc_pkg::ctc_sync_st_t st_nxt;

    // the first stage feeds only the second
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = level_in;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_out = st_r.sync;

endmodule : ctc_sync

`default_nettype wire

// [src/ctc_adc_stage.sv]
// staging and active copies of the adc-trigger thresholds a/b of three channels
// assumes writes and transfer points come from logic on ref_clk
`include "ctc_params.svh"
`default_nettype none

module ctc_adc_stage (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [`CTC_THR_W-1:0] wr_data,
    input wire logic [`CTC_NUM_CH-1:0] pause_adc,
    input wire logic [`CTC_NUM_CH-1:0] buf_en_adc,
    input wire logic [`CTC_NUM_CH-1:0] xfer_point,
    output logic [2*`CTC_NUM_CH*`CTC_THR_W-1:0] stage_q,
    output logic [2*`CTC_NUM_CH*`CTC_THR_W-1:0] act_q
);

    ctc_pkg::ctc_stage_st_t st_r;
    ctc_pkg::ctc_stage_st_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // entry i belongs to channel i/2; even entries are threshold a, odd b
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < 2*`CTC_NUM_CH; i++) begin
            // a transfer moves the staged value held before this cycle's write
            if (xfer_point[i/2] && !pause_adc[i/2] && buf_en_adc[i/2]) begin
                st_nxt.act[i] = st_r.stage[i];
            end
        end
        if (wr_en && wr_idx < 3'(2*`CTC_NUM_CH)) begin
            st_nxt.stage[wr_idx] = wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign stage_q = st_r.stage;
    assign act_q = st_r.act;

endmodule : ctc_adc_stage

`default_nettype wire

// [verification/ctc_ctrl_checker.sv]
// port assertions of the common timer control bank
// assumes a single ref_clk domain; bound to every instance of the top module
`include "ctc_params.svh"
`default_nettype none

module ctc_ctrl_checker (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [`CTC_ADDR_W-1:0] reg_addr,
    input wire logic [`CTC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`CTC_DATA_W-1:0] reg_rdata,
    input wire logic dbg_break,
    input wire logic [`CTC_PAUSE_W-1:0] buf_en,
    input wire logic [`CTC_NUM_CH-1:0] xfer_point,
    input wire logic [`CTC_NUM_CH-1:0] chan_running,
    input wire logic [`CTC_NUM_CH-1:0] cnt_enable,
    input wire logic [`CTC_NUM_CH-1:0] cnt_init,
    input wire logic [`CTC_PAUSE_W-1:0] xfer_ok,
    input wire logic read_delay_mask,
    input wire logic [2*`CTC_NUM_CH*`CTC_THR_W-1:0] adc_thr_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire wr_launch = reg_wr && (reg_addr == `CTC_OFS_LAUNCH);
    wire wr_halt = reg_wr && (reg_addr == `CTC_OFS_HALT);
    ////////////////////////////////////////////////////////////////////////////////
    AST_LAUNCH_RUNS: assert property (wr_launch |=> (chan_running & $past(reg_wdata[18:16])) == $past(reg_wdata[18:16]))
        else $error("launch bit did not start its channel");
    AST_INIT_PULSE: assert property (wr_launch |=> cnt_init == $past(reg_wdata[18:16]))
        else $error("counter reinit pulse wrong after launch");
    AST_INIT_QUIET: assert property (!wr_launch |=> cnt_init == 3'h0)
        else $error("counter reinit without launch");
    AST_HALT_STOPS: assert property (wr_halt |=> (chan_running & $past(reg_wdata[18:16])) == 3'h0)
        else $error("halt bit did not stop its channel");
    // any run change without a launch or halt write is a stray side effect
    AST_RUN_HOLD: assert property (!wr_launch && !wr_halt |=> $stable(chan_running))
        else $error("run state changed without a write");
    AST_STATUS_READ: assert property (reg_rd && reg_addr == `CTC_OFS_LAUNCH |=> reg_rdata == {13'h0, $past(chan_running), 16'h0000})
        else $error("status read does not match run state");
    AST_HALT_READ: assert property (reg_rd && reg_addr == `CTC_OFS_HALT |=> reg_rdata == 32'h0000_0000)
        else $error("halt register read not zero");
    AST_ENABLE_RUN: assert property (!dbg_break [*4] |-> cnt_enable == chan_running)
        else $error("count enable differs from run state outside break");
    AST_XFER_BLOCK: assert property (buf_en == 12'h000 |=> xfer_ok == 12'h000)
        else $error("transfer allowed without mode enable");
    AST_ADC_HOLD: assert property (xfer_point == 3'h0 |=> $stable(adc_thr_active))
        else $error("active threshold moved without transfer point");
    AST_RDMASK: assert property (reg_wr && reg_addr == `CTC_OFS_BRKSEL |=> read_delay_mask == $past(reg_wdata[15]))
        else $error("read delay mask not taken from write");
endmodule : ctc_ctrl_checker

bind ctc_common_timer_ctrl ctc_ctrl_checker u_chk (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .dbg_break, .buf_en, .xfer_point, .chan_running, .cnt_enable, .cnt_init, .xfer_ok,
    .read_delay_mask, .adc_thr_active);

`default_nettype wire

// [verification/tb.sv]
// self-checking bench of the common timer control bank
// assumes the design and checker files are compiled before it
`include "ctc_params.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic dbg_break = 1'b0;
    logic [11:0] buf_en = 12'h000;
    logic [2:0] xfer_point = 3'h0;
    logic [2:0] chan_running;
    logic [2:0] cnt_enable;
    logic [2:0] cnt_init;
    logic [11:0] xfer_ok;
    logic read_delay_mask;
    logic [95:0] adc_thr_active;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;

    always #12.5 ref_clk = ~ref_clk;

    ctc_common_timer_ctrl DUT (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .dbg_break, .buf_en, .xfer_point, .chan_running, .cnt_enable, .cnt_init, .xfer_ok,
        .read_delay_mask, .adc_thr_active);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // returns 1 ns after the taking edge so its effects can be sampled at once
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rchk

    task automatic pulse_ch1();
        @(posedge ref_clk);
        xfer_point <= 3'h2;
        @(posedge ref_clk);
        xfer_point <= 3'h0;
        #1;
    endtask : pulse_ch1
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] adr [6] = '{8'h00, 8'h04, 8'h48, 8'h4c, 8'h80, 8'h10};
        foreach (adr[i]) rchk(adr[i], 32'h0000_0000);
    endtask : t_reset

    task automatic t_launch();
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, 32'h0001_0000 << i);
            chk(cnt_init, 32'h1 << i);
            rchk(8'h00, ((32'h2 << i) - 32'h1) << 16);
        end
        wr(8'h00, 32'h0002_0000);
        chk(cnt_init, 32'h2);
        chk(chan_running, 32'h7);
        wr(8'h00, 32'hfff8_ffff);
        chk({cnt_init, chan_running}, 32'h07);
    endtask : t_launch

    task automatic t_halt();
        wr(8'h04, 32'hfff8_ffff);
        chk(chan_running, 32'h7);
        wr(8'h04, 32'h0002_0000);
        chk(chan_running, 32'h5);
        rchk(8'h04, 32'h0000_0000);
        wr(8'h04, 32'h0002_0000);
        rchk(8'h00, 32'h0005_0000);
    endtask : t_halt

    // ch1 keeps break-run low so it must freeze while the others count on
    task automatic t_break();
        wr(8'h4c, 32'hffff_ffff);
        rchk(8'h4c, 32'h0007_8000);
        chk(read_delay_mask, 32'h1);
        wr(8'h4c, 32'h0005_8000);
        wr(8'h00, 32'h0007_0000);
        @(posedge ref_clk);
        dbg_break <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        chk(cnt_enable, 32'h5);
        @(posedge ref_clk);
        dbg_break <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk(cnt_enable, 32'h7);
    endtask : t_break

    task automatic t_pause();
        @(posedge ref_clk);
        buf_en <= 12'hfff;
        for (int b = 0; b < 12; b++) begin
            wr(8'h48, 32'h1 << b);
            @(posedge ref_clk);
            #1;
            chk(xfer_ok, {20'h00000, ~(12'h001 << b)});
            rchk(8'h48, 32'h1 << b);
        end
        wr(8'h48, 32'hffff_ffff);
        rchk(8'h48, 32'h0000_0fff);
        // every pause bit goes back to zero, so only the cleared mode enables can block transfers
        wr(8'h48, 32'h0000_0000);
        @(posedge ref_clk);
        buf_en <= 12'h000;
        @(posedge ref_clk);
        #1;
        chk(xfer_ok, 32'h000);
    endtask : t_pause

    task automatic t_adc();
        wr(8'h90, 32'hffff_1234);
        wr(8'h98, 32'h0000_5678);
        rchk(8'h90, 32'h0000_1234);
        @(posedge ref_clk);
        buf_en <= 12'h080;
        wr(8'h48, 32'h0000_0080);
        pulse_ch1();
        chk(adc_thr_active[63:32], 32'h0);
        wr(8'h48, 32'h0000_0000);
        @(posedge ref_clk);
        buf_en <= 12'h000;
        pulse_ch1();
        chk(adc_thr_active[63:32], 32'h0);
        @(posedge ref_clk);
        buf_en <= 12'h080;
        pulse_ch1();
        chk(adc_thr_active[63:32], 32'h5678_1234);
        chk(adc_thr_active[31:0] | adc_thr_active[95:64], 32'h0);
    endtask : t_adc
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // the whole sequence needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            report_and_stop();
        end
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_launch();
        t_halt();
        t_break();
        t_pause();
        t_adc();
        report_and_stop();
    end
endmodule : tb

`default_nettype wire
